// >>> core/bus_if_pkg.sv
// Package: encodings and timing constants shared by both bus ends
package bus_if_pkg;

  // ************************************************************
  // Transfer encodings
  // ************************************************************
  localparam logic [1:0] TRAN_ADDR_ONLY = 2'h0;
  localparam logic [1:0] TRAN_NONSEQ    = 2'h1;
  localparam logic [1:0] TRAN_SEQ       = 2'h3;

  localparam logic [1:0] SIZE_BYTE      = 2'h0;
  localparam logic [1:0] SIZE_HALF      = 2'h1;
  localparam logic [1:0] SIZE_WORD      = 2'h2;

  localparam logic [1:0] BURST_NONE     = 2'h0;
  localparam logic [1:0] BURST_FOUR     = 2'h1;
  localparam logic [1:0] BURST_EIGHT    = 2'h2;

  localparam int         PROT_DATA_BIT  = 0;
  localparam int         PROT_PRIV_BIT  = 1;

  localparam logic [3:0] BURST_LEN_FOUR  = 4'h4;
  localparam logic [3:0] BURST_LEN_EIGHT = 4'h8;
  localparam logic [3:0] ONE_WORD        = 4'h1;
  // Strobe to first answer: system register plus two sync flops
  localparam logic [1:0] RESP_LATENCY    = 2'h3;

  // ************************************************************
  // Bus reset timing
  // ************************************************************
  localparam int         CLK_PERIOD_NS     = 20;
  localparam int         RESET_MIN_CYCLES  = 5;
  localparam logic [2:0] RESET_HOLD_CNT    = 3'(RESET_MIN_CYCLES);

  // ************************************************************
  // Slave response from one wait/error/last triple
  // ************************************************************
  typedef enum logic [1:0] {RESP_OKAY, RESP_WAIT, RESP_ERROR, RESP_RETRACT}
    resp_kind_t;

  function automatic resp_kind_t decode_resp(input logic wt,
                                             input logic er,
                                             input logic la);
    if (wt)
      return RESP_WAIT;
    else if (er && la)
      return RESP_RETRACT;
    else if (er)
      return RESP_ERROR;
    else
      return RESP_OKAY;
  endfunction : decode_resp

endpackage : bus_if_pkg

// >>> core/sys_bus_if.sv
// Interface: shared system bus between processor master and system side
`timescale 1ns/1ps
interface sys_bus_if;
  logic        arbiter_grant;
  logic        slave_wait_resp_in;
  logic        slave_error_resp_in;
  logic        slave_last_resp_in;
  logic        bus_reset_n;
  logic        test_select;
  logic        direction_in;
  logic [31:0] addr;
  logic [1:0]  tran_type;
  logic [1:0]  xfer_size;
  logic [1:0]  burst;
  logic [1:0]  protection_info;
  logic        direction_out;
  logic        locked_transfer;
  logic        transfer_strobe;
  logic        noncached_more_words;
  logic        bus_request;
  logic        test_wait_resp_out;
  logic        test_error_resp_out;
  logic        test_last_resp_out;
  logic        resp_tristate_en;

  modport master (
    input  arbiter_grant, slave_wait_resp_in, slave_error_resp_in,
           slave_last_resp_in, bus_reset_n, test_select, direction_in,
    output addr, tran_type, xfer_size, burst, protection_info,
           direction_out, locked_transfer, transfer_strobe,
           noncached_more_words, bus_request, test_wait_resp_out,
           test_error_resp_out, test_last_resp_out, resp_tristate_en
  );

  modport system (
    output arbiter_grant, slave_wait_resp_in, slave_error_resp_in,
           slave_last_resp_in, bus_reset_n, test_select, direction_in,
    input  addr, tran_type, xfer_size, burst, protection_info,
           direction_out, locked_transfer, transfer_strobe,
           noncached_more_words, bus_request, test_wait_resp_out,
           test_error_resp_out, test_last_resp_out, resp_tristate_en
  );
endinterface : sys_bus_if

// >>> core/bus_master_end.sv
// Processor-side bus master: request, transfer sequencing, test slave
// Overview of operation
// - Error response high marks a failed transfer
// - Error with last means retract, not error
// - Last high ends the burst at once
// - Lock asserted with strobe for indivisible pair
// - More-words high until final noncached burst word; dropped early while grant is lost
// - Protection bit zero: fetch 0, data 1
// - Protection bit one: user 0, supervisor 1
// - Size codes word 10, half 01, byte 00
// - Transfer type 00 idle, 01 nonseq, 11 seq
// - Wait high extends the current transfer
// - Direction high for write, low for read
// - Tristate enable gates test slave responses
// - Test slave drives own wait/error/last responses
// - Grant counts only while wait is low
// - Burst code 01 four words, 10 eight
// - Bus reset held at least five cycles by system
`timescale 1ns/1ps
module bus_master_end
  import bus_if_pkg::*;
(
  input  wire logic        sys_clk,      // System clock, 50 MHz
  input  wire logic        rst,          // Asynchronous reset, active high
  sys_bus_if.master        bus,          // Shared system bus
  input  wire logic        req_valid,    // Request a transfer
  input  wire logic [31:0] req_addr,     // Start address
  input  wire logic        req_write,    // Write when high
  input  wire logic [1:0]  req_size,     // Size code
  input  wire logic [3:0]  req_len,      // Words: 1, 4 or 8
  input  wire logic        req_data,     // Data access, else fetch
  input  wire logic        req_priv,     // Privileged access
  input  wire logic        req_lock,     // Lock with following transfer
  input  wire logic        req_noncached, // Noncached load multiple
  output logic             req_ready,    // Idle, request taken
  output logic             done_pulse,   // Transfer sequence ended
  output logic             done_error,   // Ended with error
  output logic             done_retract, // Ended with retract
  output logic             done_last     // Ended early by last response
);

  // ************************************************************
  // Input synchronisers (bus pins are outside this domain)
  // ************************************************************
  logic [6:0] sync1_r, sync2_r;
  logic       gnt, wt, er, la, brst_n, tsel, tdir;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync1_r <= 7'h00;
      sync2_r <= 7'h00;
    end else begin
      sync1_r <= {bus.arbiter_grant, bus.slave_wait_resp_in,
                  bus.slave_error_resp_in, bus.slave_last_resp_in,
                  bus.bus_reset_n, bus.test_select, bus.direction_in};
      sync2_r <= sync1_r;
    end
  end
  assign {gnt, wt, er, la, brst_n, tsel, tdir} = sync2_r;

  // ************************************************************
  // Transfer sequencer
  // ************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_XFER} state_t;

  state_t      state_r,   state_nxt;
  logic [31:0] addr_r,    addr_nxt;
  logic [1:0]  tran_r,    tran_nxt;
  logic [1:0]  size_r,    size_nxt;
  logic [1:0]  burst_r,   burst_nxt;
  logic [1:0]  prot_r,    prot_nxt;
  logic        dir_r,     dir_nxt;
  logic        lock_r,    lock_nxt;
  logic        strobe_r,  strobe_nxt;
  logic        more_r,    more_nxt;
  logic        nc_r,      nc_nxt;
  logic        breq_r,    breq_nxt;
  logic [3:0]  left_r,    left_nxt;
  logic        ready_r,   ready_nxt;
  logic        done_r,    done_nxt;
  logic        derr_r,    derr_nxt;
  logic        dret_r,    dret_nxt;
  logic        dlast_r,   dlast_nxt;
  logic        lkp_r,     lkp_nxt;
  logic [1:0]  lat_r,     lat_nxt;
  resp_kind_t  resp;

  function automatic logic [1:0] burst_code(input logic [3:0] len);
    if (len == BURST_LEN_FOUR)
      return BURST_FOUR;
    else if (len == BURST_LEN_EIGHT)
      return BURST_EIGHT;
    else
      return BURST_NONE;
  endfunction : burst_code

  always_comb begin
    resp       = decode_resp(wt, er, la);
    state_nxt  = state_r;
    addr_nxt   = addr_r;
    tran_nxt   = tran_r;
    size_nxt   = size_r;
    burst_nxt  = burst_r;
    prot_nxt   = prot_r;
    dir_nxt    = dir_r;
    lock_nxt   = lock_r;
    strobe_nxt = strobe_r;
    more_nxt   = more_r;
    nc_nxt     = nc_r;
    breq_nxt   = breq_r;
    left_nxt   = left_r;
    ready_nxt  = ready_r;
    done_nxt   = 1'b0;
    derr_nxt   = derr_r;
    dret_nxt   = dret_r;
    dlast_nxt  = dlast_r;
    lkp_nxt    = lkp_r;
    lat_nxt    = lat_r;
    unique case (state_r)
      ST_IDLE: begin
        if (req_valid && ready_r) begin
          addr_nxt  = req_addr;
          size_nxt  = (req_size == SIZE_HALF) ? SIZE_HALF :
                      (req_size == SIZE_BYTE) ? SIZE_BYTE :
                      SIZE_WORD;
          dir_nxt   = req_write;
          prot_nxt[PROT_DATA_BIT] = req_data;
          prot_nxt[PROT_PRIV_BIT] = req_priv;
          burst_nxt = burst_code(req_len);
          left_nxt  = (req_len == 4'h0) ? ONE_WORD : req_len;
          nc_nxt    = req_noncached;
          lkp_nxt   = req_lock;
          breq_nxt  = 1'b1;
          ready_nxt = 1'b0;
          state_nxt = ST_REQ;
        end else begin
          // Held low below while the system keeps the bus in reset
          ready_nxt = 1'b1;
        end
      end
      ST_REQ: begin
        // Bus owned only once the previous owner is no longer waiting
        if (gnt && !wt) begin
          tran_nxt   = TRAN_NONSEQ;
          strobe_nxt = 1'b1;
          lock_nxt   = lkp_r;
          lat_nxt    = RESP_LATENCY;
          more_nxt   = nc_r && (left_r != ONE_WORD);
          state_nxt  = ST_XFER;
        end
      end
      ST_XFER: begin
        // Answers still in the sync pipe predate this strobe
        if (lat_r != 2'h0)
          lat_nxt = lat_r - 2'h1;
        else unique case (resp)
          RESP_WAIT: begin
            // Hold all address-phase outputs while extended
            state_nxt = ST_XFER;
          end
          RESP_OKAY: begin
            if (left_r == ONE_WORD || la) begin
              dlast_nxt = la && (left_r != ONE_WORD);
              derr_nxt  = 1'b0;
              dret_nxt  = 1'b0;
              state_nxt = ST_IDLE;
            end else begin
              left_nxt = left_r - ONE_WORD;
              addr_nxt = addr_r + 32'h4;
              tran_nxt = TRAN_SEQ;
              more_nxt = nc_r && (left_r != 4'h2);
            end
          end
          RESP_ERROR, RESP_RETRACT: begin
            derr_nxt  = (resp == RESP_ERROR);
            dret_nxt  = (resp == RESP_RETRACT);
            dlast_nxt = 1'b0;
            state_nxt = ST_IDLE;
          end
        endcase
        // Lost grant voids the more-words hint; the burst itself carries on
        if (!gnt && resp != RESP_WAIT && lat_r == 2'h0)
          more_nxt = 1'b0;
        if (state_nxt == ST_IDLE) begin
          tran_nxt   = TRAN_ADDR_ONLY;
          strobe_nxt = 1'b0;
          lock_nxt   = 1'b0;
          more_nxt   = 1'b0;
          burst_nxt  = BURST_NONE;
          breq_nxt   = 1'b0;
          ready_nxt  = 1'b1;
          done_nxt   = 1'b1;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    // Bus reset from the system acts as a soft abort
    if (!brst_n) begin
      state_nxt  = ST_IDLE;
      tran_nxt   = TRAN_ADDR_ONLY;
      strobe_nxt = 1'b0;
      lock_nxt   = 1'b0;
      more_nxt   = 1'b0;
      breq_nxt   = 1'b0;
      ready_nxt  = 1'b0;
      done_nxt   = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r  <= ST_IDLE;
      addr_r   <= 32'h0;
      tran_r   <= TRAN_ADDR_ONLY;
      size_r   <= SIZE_WORD;
      burst_r  <= BURST_NONE;
      prot_r   <= 2'h0;
      dir_r    <= 1'b0;
      lock_r   <= 1'b0;
      strobe_r <= 1'b0;
      more_r   <= 1'b0;
      nc_r     <= 1'b0;
      breq_r   <= 1'b0;
      left_r   <= ONE_WORD;
      ready_r  <= 1'b0;
      done_r   <= 1'b0;
      derr_r   <= 1'b0;
      dret_r   <= 1'b0;
      dlast_r  <= 1'b0;
      lkp_r    <= 1'b0;
      lat_r    <= 2'h0;
    end else begin
      state_r  <= state_nxt;
      addr_r   <= addr_nxt;
      tran_r   <= tran_nxt;
      size_r   <= size_nxt;
      burst_r  <= burst_nxt;
      prot_r   <= prot_nxt;
      dir_r    <= dir_nxt;
      lock_r   <= lock_nxt;
      strobe_r <= strobe_nxt;
      more_r   <= more_nxt;
      nc_r     <= nc_nxt;
      breq_r   <= breq_nxt;
      left_r   <= left_nxt;
      ready_r  <= ready_nxt;
      done_r   <= done_nxt;
      derr_r   <= derr_nxt;
      dret_r   <= dret_nxt;
      dlast_r  <= dlast_nxt;
      lkp_r    <= lkp_nxt;
      lat_r    <= lat_nxt;
    end
  end

  // ************************************************************
  // Test slave responses
  // ************************************************************
  // Always completes in one cycle, never errors: a trivial test target
  logic tsr_en_r, tsr_en_nxt, twait_r, twait_nxt;
  logic terr_r, terr_nxt, tlast_r, tlast_nxt;

  always_comb begin
    tsr_en_nxt = tsel;
    twait_nxt  = 1'b0;
    terr_nxt   = 1'b0;
    tlast_nxt  = tsel && tdir;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tsr_en_r <= 1'b0;
      twait_r  <= 1'b0;
      terr_r   <= 1'b0;
      tlast_r  <= 1'b0;
    end else begin
      tsr_en_r <= tsr_en_nxt;
      twait_r  <= twait_nxt;
      terr_r   <= terr_nxt;
      tlast_r  <= tlast_nxt;
    end
  end

  assign bus.addr                 = addr_r;
  assign bus.tran_type            = tran_r;
  assign bus.xfer_size            = size_r;
  assign bus.burst                = burst_r;
  assign bus.protection_info      = prot_r;
  assign bus.direction_out        = dir_r;
  assign bus.locked_transfer      = lock_r;
  assign bus.transfer_strobe      = strobe_r;
  assign bus.noncached_more_words = more_r;
  assign bus.bus_request          = breq_r;
  assign bus.test_wait_resp_out   = twait_r;
  assign bus.test_error_resp_out  = terr_r;
  assign bus.test_last_resp_out   = tlast_r;
  assign bus.resp_tristate_en     = tsr_en_r;
  assign req_ready    = ready_r;
  assign done_pulse   = done_r;
  assign done_error   = derr_r;
  assign done_retract = dret_r;
  assign done_last    = dlast_r;

endmodule : bus_master_end

// >>> core/bus_system_end.sv
// System side: arbiter grant, slave responses and bus reset generator
`timescale 1ns/1ps
module bus_system_end
  import bus_if_pkg::*;
(
  input  wire logic  sys_clk,       // System clock, 50 MHz
  input  wire logic  rst,           // Asynchronous reset, active high
  sys_bus_if.system  bus,           // Shared system bus
  input  wire logic  grant_en,      // Allow grant to the master
  input  wire logic  slv_wait,      // Slave asks for another cycle
  input  wire logic  slv_error,     // Slave reports error
  input  wire logic  slv_last,      // Slave ends the burst
  input  wire logic  test_sel,      // Select master as test slave
  input  wire logic  test_write,    // Test access direction
  output logic       xfer_seen,     // Strobed transfer completed
  output logic       lock_seen      // Locked transfer strobed last cycle
);

  // ************************************************************
  // Bus reset: held low a fixed count after system reset
  // ************************************************************
  logic [2:0] rcnt_r, rcnt_nxt;
  logic       brst_n_r, brst_n_nxt;

  always_comb begin
    rcnt_nxt   = rcnt_r;
    brst_n_nxt = brst_n_r;
    if (rcnt_r != 3'h0)
      rcnt_nxt = rcnt_r - 3'h1;
    else
      brst_n_nxt = 1'b1;
  end

  // ************************************************************
  // Grant and slave responses
  // ************************************************************
  logic gnt_r, gnt_nxt, wt_r, wt_nxt, er_r, er_nxt, la_r, la_nxt;
  logic ts_r, ts_nxt, td_r, td_nxt, seen_r, seen_nxt, lk_r, lk_nxt;
  logic        sdly_r, sdly_nxt;
  logic [31:0] adly_r, adly_nxt;

  always_comb begin
    gnt_nxt  = grant_en && bus.bus_request;
    wt_nxt   = slv_wait && bus.transfer_strobe;
    er_nxt   = slv_error && bus.transfer_strobe && !slv_wait;
    la_nxt   = slv_last && bus.transfer_strobe && !slv_wait;
    ts_nxt   = test_sel;
    td_nxt   = test_write;
    sdly_nxt = bus.transfer_strobe;
    adly_nxt = bus.addr;
    // A word ends when the address steps on or the strobe drops
    seen_nxt = sdly_r && (!bus.transfer_strobe || bus.addr != adly_r);
    lk_nxt   = bus.locked_transfer && bus.transfer_strobe;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rcnt_r   <= RESET_HOLD_CNT;
      brst_n_r <= 1'b0;
      gnt_r    <= 1'b0;
      wt_r     <= 1'b0;
      er_r     <= 1'b0;
      la_r     <= 1'b0;
      ts_r     <= 1'b0;
      td_r     <= 1'b0;
      seen_r   <= 1'b0;
      lk_r     <= 1'b0;
      sdly_r   <= 1'b0;
      adly_r   <= 32'h0;
    end else begin
      rcnt_r   <= rcnt_nxt;
      brst_n_r <= brst_n_nxt;
      gnt_r    <= gnt_nxt;
      wt_r     <= wt_nxt;
      er_r     <= er_nxt;
      la_r     <= la_nxt;
      ts_r     <= ts_nxt;
      td_r     <= td_nxt;
      seen_r   <= seen_nxt;
      lk_r     <= lk_nxt;
      sdly_r   <= sdly_nxt;
      adly_r   <= adly_nxt;
    end
  end

  assign bus.bus_reset_n         = brst_n_r;
  assign bus.arbiter_grant       = gnt_r;
  assign bus.slave_wait_resp_in  = wt_r;
  assign bus.slave_error_resp_in = er_r;
  assign bus.slave_last_resp_in  = la_r;
  assign bus.test_select         = ts_r;
  assign bus.direction_in        = td_r;
  assign xfer_seen = seen_r;
  assign lock_seen = lk_r;

endmodule : bus_system_end

// >>> dv/bus_monitor.sv
// Checker: concurrent properties on the shared system bus
`timescale 1ns/1ps
module bus_monitor
  import bus_if_pkg::*;
(
  input wire logic        sys_clk,              // System clock
  input wire logic        rst,                  // Reset, active high
  input wire logic        slave_wait_resp_in,   // Slave wait
  input wire logic        bus_reset_n,          // Bus reset, active low
  input wire logic        test_select,          // Test slave select
  input wire logic [31:0] addr,                 // Address
  input wire logic [1:0]  tran_type,            // Transfer type
  input wire logic [1:0]  xfer_size,            // Size code
  input wire logic [1:0]  protection_info,      // Protection bits
  input wire logic        direction_out,        // Direction
  input wire logic        locked_transfer,      // Lock
  input wire logic        transfer_strobe,      // Strobe
  input wire logic        noncached_more_words, // More words
  input wire logic        bus_request,          // Bus request
  input wire logic        test_wait_resp_out,   // Test wait
  input wire logic        test_error_resp_out,  // Test error
  input wire logic        resp_tristate_en      // Response enable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ************************************************************
  // Bus reset low-time counter
  // ************************************************************
  logic [3:0] low_cnt_r;
  logic [3:0] low_cnt_nxt;

  // Saturates so a long hold never wraps into a short count
  always_comb begin
    low_cnt_nxt = low_cnt_r;
    if (bus_reset_n)
      low_cnt_nxt = 4'h0;
    else if (low_cnt_r != 4'hf)
      low_cnt_nxt = low_cnt_r + 4'h1;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      low_cnt_r <= 4'h0;
    else
      low_cnt_r <= low_cnt_nxt;
  end

  // ************************************************************
  // Properties
  // ************************************************************
  a_size_legal: assert property (xfer_size != 2'h3)
    else $error("size code 11 driven");
  a_tran_legal: assert property (tran_type != 2'h2)
    else $error("reserved transfer type driven");
  a_tran_idle: assert property (
    !transfer_strobe |-> tran_type == TRAN_ADDR_ONLY)
    else $error("transfer type not idle without strobe");
  a_nonseq_start: assert property (
    $rose(transfer_strobe) |-> tran_type == TRAN_NONSEQ && bus_request)
    else $error("sequence did not open nonsequential");
  a_lock_strobe: assert property (
    $rose(locked_transfer) |-> $rose(transfer_strobe))
    else $error("lock raised apart from strobe");
  a_hold_in_wait: assert property (
    slave_wait_resp_in [*5] ##0 (transfer_strobe && $past(transfer_strobe))
    |-> $stable(addr) && $stable(xfer_size) && $stable(protection_info)
        && $stable(direction_out) && $stable(locked_transfer))
    else $error("address or control moved during wait");
  a_seq_advance: assert property (
    transfer_strobe && $past(transfer_strobe) && addr != $past(addr)
    |-> addr == $past(addr) + 32'h4 && tran_type == TRAN_SEQ)
    else $error("bad burst address step");
  a_more_in_xfer: assert property (
    noncached_more_words |-> transfer_strobe)
    else $error("more words outside a transfer");
  a_test_quiet: assert property (
    !test_wait_resp_out && !test_error_resp_out)
    else $error("test slave gave wait or error");
  a_tristate_on: assert property (
    $rose(test_select) |-> ##[1:4] resp_tristate_en)
    else $error("response enable did not follow select");
  a_reset_hold: assert property (
    $rose(bus_reset_n) |-> low_cnt_r >= 4'(RESET_MIN_CYCLES))
    else $error("bus reset released too early");
endmodule : bus_monitor

// >>> dv/tb_top.sv
// Testbench: master and system ends joined over the shared bus
`timescale 1ns/1ps
module tb_top;
  import bus_if_pkg::*;

  logic        sys_clk, rst, req_valid, req_write, req_data, req_priv;
  logic        req_lock, req_noncached, req_ready, done_pulse, done_error;
  logic        done_retract, done_last, grant_en, slv_wait, slv_error;
  logic        slv_last, test_sel, test_write, xfer_seen, lock_seen;
  logic [31:0] req_addr;
  logic [1:0]  req_size;
  logic [3:0]  req_len;
  logic [42:0] req_f;
  int          errors, n_checks;

  assign {req_addr, req_write, req_size, req_len, req_priv, req_data,
          req_lock, req_noncached} = req_f;

  sys_bus_if link ();

  bus_master_end bus_master_end_i (.sys_clk(sys_clk), .rst(rst),
    .bus(link), .req_valid(req_valid), .req_addr(req_addr),
    .req_write(req_write), .req_size(req_size), .req_len(req_len),
    .req_data(req_data), .req_priv(req_priv), .req_lock(req_lock),
    .req_noncached(req_noncached), .req_ready(req_ready),
    .done_pulse(done_pulse), .done_error(done_error),
    .done_retract(done_retract), .done_last(done_last));

  bus_system_end bus_system_end_i (.sys_clk(sys_clk), .rst(rst),
    .bus(link), .grant_en(grant_en), .slv_wait(slv_wait),
    .slv_error(slv_error), .slv_last(slv_last), .test_sel(test_sel),
    .test_write(test_write), .xfer_seen(xfer_seen), .lock_seen(lock_seen));

  bus_monitor bus_monitor_i (.sys_clk(sys_clk), .rst(rst),
    .slave_wait_resp_in(link.slave_wait_resp_in),
    .bus_reset_n(link.bus_reset_n), .test_select(link.test_select),
    .addr(link.addr), .tran_type(link.tran_type),
    .xfer_size(link.xfer_size), .protection_info(link.protection_info),
    .direction_out(link.direction_out),
    .locked_transfer(link.locked_transfer),
    .transfer_strobe(link.transfer_strobe),
    .noncached_more_words(link.noncached_more_words),
    .bus_request(link.bus_request),
    .test_wait_resp_out(link.test_wait_resp_out),
    .test_error_resp_out(link.test_error_resp_out),
    .resp_tristate_en(link.resp_tristate_en));

  always #10 sys_clk = ~sys_clk;

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wait_ready();
    int k;
    for (k = 0; k < 50 && req_ready !== 1'b1; k++) @(posedge sys_clk);
    if (req_ready !== 1'b1) begin
      errors++;
      $display("[ERR] req_ready expected 1 seen %b", req_ready);
      complete_run();
    end
  endtask : wait_ready

  // One request; slave answers as told; hold_g withholds grant a while
  task automatic xfer(input logic [31:0] a, input logic w,
    input logic [1:0] sz, input logic [3:0] ln, input logic [1:0] pd,
    input logic lk, input logic nc, input int wt, input logic er,
    input logic la, input int hold_g);
    int k, n, words, nx, nl;
    logic [31:0] last_a;
    logic last_mw, started;
    n = 0;
    nx = 0;
    nl = 0;
    started = 1'b0;
    last_a = 32'h0;
    last_mw = 1'b0;
    words = (er || la || ln < 4'h2) ? 1 : int'(ln);
    slv_error <= er;
    slv_last <= la;
    if (hold_g > 0) begin
      grant_en <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
    wait_ready();
    req_valid <= 1'b1;
    req_f <= {a, w, sz, ln, pd, lk, nc};
    for (k = 0; k < 300 && done_pulse !== 1'b1; k++) begin
      @(posedge sys_clk);
      if (k == 0) req_valid <= 1'b0;
      if (hold_g > 0 && k == hold_g) begin
        chk("strobe_no_grant", link.transfer_strobe, 0);
        chk("request_held", link.bus_request, 1);
        grant_en <= 1'b1;
      end
      if (link.transfer_strobe === 1'b1 && !started) begin
        started = 1'b1;
        chk("tran_first", link.tran_type, TRAN_NONSEQ);
        chk("size", link.xfer_size, sz);
        chk("prot", link.protection_info, pd);
        chk("dir", link.direction_out, w);
        chk("lock", link.locked_transfer, lk);
        chk("burst", link.burst, ln == 4'h4 ? BURST_FOUR :
            ln == 4'h8 ? BURST_EIGHT : BURST_NONE);
        chk("more_first", link.noncached_more_words, nc && words > 1);
      end
      if (link.transfer_strobe === 1'b1) begin
        n++;
        // Slave waits for the first wt strobe cycles it sees
        slv_wait <= (n <= wt);
        last_a = link.addr;
        last_mw = link.noncached_more_words;
      end
      nx += int'(xfer_seen);
      nl += int'(lock_seen);
    end
    if (done_pulse !== 1'b1) begin
      errors++;
      $display("[ERR] done_pulse expected 1 seen %b", done_pulse);
      complete_run();
    end
    slv_wait <= 1'b0;
    slv_error <= 1'b0;
    slv_last <= 1'b0;
    // Pulses may trail the done flag by a cycle or two
    repeat (3) begin
      @(posedge sys_clk);
      nx += int'(xfer_seen);
      nl += int'(lock_seen);
    end
    chk("done_error", done_error, er && !la);
    chk("done_retract", done_retract, er && la);
    chk("done_last", done_last, la && !er);
    chk("end_addr", last_a, a + 32'(4 * (words - 1)));
    chk("more_last", last_mw, 0);
    if (!er) chk("words", nx, words);
    chk("lock_seen", nl != 0, lk);
  endtask : xfer

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    req_valid = 1'b0;
    req_f = '0;
    grant_en = 1'b1;
    slv_wait = 1'b0;
    slv_error = 1'b0;
    slv_last = 1'b0;
    test_sel = 1'b0;
    test_write = 1'b0;
    errors = 0;
    n_checks = 0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    xfer(32'h100, 0, SIZE_BYTE, 4'h1, 2'h0, 0, 0, 0, 0, 0, 0);
    xfer(32'h200, 1, SIZE_HALF, 4'h1, 2'h3, 0, 0, 2, 0, 0, 6);
    xfer(32'h1000, 0, SIZE_WORD, 4'h4, 2'h1, 0, 1, 6, 0, 0, 0);
    xfer(32'h2000, 1, SIZE_WORD, 4'h8, 2'h3, 1, 0, 0, 0, 0, 0);
    xfer(32'h300, 0, SIZE_WORD, 4'h1, 2'h1, 0, 0, 0, 1, 0, 0);
    xfer(32'h400, 0, SIZE_WORD, 4'h4, 2'h1, 0, 0, 0, 1, 1, 0);
    xfer(32'h500, 0, SIZE_WORD, 4'h8, 2'h2, 0, 0, 0, 0, 1, 0);
    // Second reset in mid-run, then traffic must resume cleanly
    rst <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    xfer(32'h600, 1, SIZE_HALF, 4'h4, 2'h2, 1, 0, 1, 0, 0, 0);
    test_sel <= 1'b1;
    test_write <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk("ts_en", link.resp_tristate_en, 1);
    chk("ts_last", link.test_last_resp_out, 1);
    chk("ts_wait", link.test_wait_resp_out, 0);
    chk("ts_err", link.test_error_resp_out, 0);
    test_write <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk("ts_last_rd", link.test_last_resp_out, 0);
    test_sel <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk("ts_off", link.resp_tristate_en, 0);
    complete_run();
  end
endmodule : tb_top
